/* File: core/ccsr_pkg.sv */
// Shared constants, types and carriers of the core special register block.
// Assumes a single synchronous core clock; holds definitions only.
package ccsr_pkg;

  // ****************************************************************
  // Special register addresses
  // ****************************************************************
  localparam logic [7:0] CCSR_ADDR_SP  = 8'h81;  // Stack top pointer
  localparam logic [7:0] CCSR_ADDR_DPL = 8'h82;  // Data pointer low byte
  localparam logic [7:0] CCSR_ADDR_DPH = 8'h83;  // Data pointer high byte
  localparam logic [7:0] CCSR_ADDR_PSW = 8'hD0;  // Processor flags word
  localparam logic [7:0] CCSR_ADDR_ACC = 8'hE0;  // Primary operand
  localparam logic [7:0] CCSR_ADDR_B   = 8'hF0;  // Secondary operand

  // ****************************************************************
  // Reset values and write masks
  // ****************************************************************
  localparam logic [7:0] CCSR_RST_SP    = 8'h07;  // Stack starts below bank 1
  localparam logic [7:0] CCSR_RST_ZERO  = 8'h00;  // All other registers
  localparam logic [7:0] CCSR_MASK_ALL  = 8'hFF;  // Every bit writable
  localparam logic [7:0] CCSR_MASK_NONE = 8'h00;  // No hardware update
  localparam logic [7:0] CCSR_PSW_WMASK = 8'hFE;  // Parity bit is read only

  // ****************************************************************
  // Flags word field positions
  // ****************************************************************
  localparam int CCSR_CY_BIT  = 7;  // Carry flag
  localparam int CCSR_AC_BIT  = 6;  // Half carry flag
  localparam int CCSR_UF0_BIT = 5;  // User flag zero
  localparam int CCSR_BSH_BIT = 4;  // Bank select high
  localparam int CCSR_BSL_BIT = 3;  // Bank select low
  localparam int CCSR_OV_BIT  = 2;  // Range error flag
  localparam int CCSR_UF1_BIT = 1;  // User flag one
  localparam int CCSR_PAR_BIT = 0;  // Parity flag

  localparam int CCSR_BIT_LSB_W = 3;  // Bit addressable: low three address bits zero
  localparam int CCSR_BANK_SHIFT = 3; // Eight bytes per working bank

  // ****************************************************************
  // Arithmetic operations
  // ****************************************************************
  typedef enum logic [2:0] {
    CCSR_OP_SUM,
    CCSR_OP_SUM_WITH_CARRY,
    CCSR_OP_DIFF_WITH_BORROW,
    CCSR_OP_PRODUCT,
    CCSR_OP_QUOTIENT
  } ccsr_op_kind_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       rd;       // Read strobe
    logic       wr;       // Write strobe
    logic       bit_op;   // Single bit access
    logic [7:0] addr;     // Special register address
    logic [2:0] bit_pos;  // Bit within the byte
    logic [7:0] wdata;    // Byte data, or bit value in bit 0
  } ccsr_sfr_req_t;

  typedef struct packed {
    logic          valid;    // Operation completes this cycle
    ccsr_op_kind_t kind;     // Which operation
    logic [7:0]    operand;  // Second operand of sum and difference
  } ccsr_arith_req_t;

  typedef struct packed {
    logic       push;  // Store a byte on the stack
    logic       pop;   // Remove a byte from the stack
    logic [7:0] data;  // Byte to store
  } ccsr_stack_req_t;

  typedef struct packed {
    logic       wr;    // Memory write strobe
    logic       rd;    // Memory read strobe
    logic [7:0] addr;  // Data memory location
    logic [7:0] data;  // Byte to write
  } ccsr_stack_out_t;

  typedef struct packed {
    logic cy;  // Carry or borrow
    logic ac;  // Nibble carry or borrow
    logic ov;  // Range error
  } ccsr_flags_t;

  typedef struct packed {
    logic [15:0] data_pointer_pair;  // Data pointer pair
    logic [7:0]  sp;    // Stack top pointer
    logic [7:0]  processor_flags_word;   // Processor flags word
    logic [7:0]  acc;   // Primary operand
    logic [7:0]  b;     // Secondary operand
  } ccsr_view_t;

endpackage

/* File: core/ccsr_sfr_reg.sv */
// One special register with byte and single bit software writes.
// Assumes the owner merges hardware updates through hw_mask and hw_val.
`timescale 1ns/1ps
module ccsr_sfr_reg
  import ccsr_pkg::*;
#(
  parameter logic [7:0] ADDR  = 8'h00,
  parameter logic [7:0] RESET = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
)
(
  input  logic          sys_clk,
  input  logic          arst_n,
  input  ccsr_sfr_req_t req,
  input  logic [7:0]    hw_mask,
  input  logic [7:0]    hw_val,
  output logic          hit,
  output logic [7:0]    d,
  output logic [7:0]    q
);

  // Bit access only where the address ends in 0 or 8
  localparam logic BITABLE = (ADDR[CCSR_BIT_LSB_W-1:0] == '0);

  logic [7:0] onehot;    // Selected bit
  logic       byte_we;   // Whole byte write
  logic       bit_we;    // Single bit write
  logic [7:0] sw_val;    // Value after software write

  assign hit     = (req.addr == ADDR);
  assign onehot  = 8'h01 << req.bit_pos;
  assign byte_we = req.wr & ~req.bit_op & hit;
  assign bit_we  = req.wr & req.bit_op & hit & BITABLE;
  assign sw_val  = byte_we ? ((q & ~WMASK) | (req.wdata & WMASK)) :
                   bit_we  ? ((q & ~(onehot & WMASK)) | ({8{req.wdata[0]}} & onehot & WMASK)) :
                   q;
  // Hardware updates win over software in the same cycle
  assign d       = (sw_val & ~hw_mask) | (hw_val & hw_mask);

  // ****************************************************************
  // Storage
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= RESET;
    else
      q <= d;
  end

endmodule

/* File: core/ccsr_arith.sv */
// Result and flag computation for sum, difference, product and quotient.
// Purely combinational; the caller decides when results are taken.
`timescale 1ns/1ps
module ccsr_arith
  import ccsr_pkg::*;
(
  input  ccsr_op_kind_t kind,
  input  logic [7:0]    a,
  input  logic [7:0]    b,
  input  logic          cin,
  output logic [7:0]    res_lo,
  output logic [7:0]    res_hi,
  output ccsr_flags_t   flags
);

  logic [8:0]  sum9;   // Sum with carry out
  logic [4:0]  nib_s;  // Low nibble sum
  logic [8:0]  dif9;   // Difference with borrow out
  logic [4:0]  nib_d;  // Low nibble difference
  logic [15:0] prod;   // Full product
  logic        cadd;   // Carry in used by the operation
  logic        bz;     // Divisor is zero

  assign cadd  = (kind == CCSR_OP_SUM) ? 1'b0 : cin;
  assign sum9  = {1'b0, a} + {1'b0, b} + {8'h00, cadd};
  assign nib_s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cadd};
  assign dif9  = {1'b0, a} - {1'b0, b} - {8'h00, cin};
  assign nib_d = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
  assign prod  = {8'h00, a} * {8'h00, b};
  assign bz    = (b == 8'h00);

  // ****************************************************************
  // Operation select
  // ****************************************************************
  always_comb
  begin
    res_lo = a;
    res_hi = b;
    flags  = '0;
    unique case (kind)
      CCSR_OP_SUM, CCSR_OP_SUM_WITH_CARRY:
      begin
        res_lo   = sum9[7:0];
        flags.cy = sum9[8];
        flags.ac = nib_s[4];
        flags.ov = (a[7] == b[7]) && (sum9[7] != a[7]);
      end
      CCSR_OP_DIFF_WITH_BORROW:
      begin
        res_lo   = dif9[7:0];
        flags.cy = dif9[8];
        flags.ac = nib_d[4];
        flags.ov = (a[7] != b[7]) && (dif9[7] != a[7]);
      end
      CCSR_OP_PRODUCT:
      begin
        res_lo   = prod[7:0];
        res_hi   = prod[15:8];
        flags.ov = (prod[15:8] != 8'h00);
      end
      CCSR_OP_QUOTIENT:
      begin
        // Zero divisor leaves both operands untouched
        res_lo   = bz ? a : a / b;
        res_hi   = bz ? b : a % b;
        flags.ov = bz;
      end
      default:
      begin
        // Illegal code: no result, flags clear
        res_lo = a;
      end
    endcase
  end

endmodule

/* File: core/ccsr_core.sv */
// Core special registers: data pointer, stack top pointer, flags word,
// primary and secondary operand, with byte and bit access.
// Assumes the instruction sequencer drives one request per kind per cycle.
`timescale 1ns/1ps

// What this block does
// - Data pointer low byte at 0x82, reset zero
// - Data pointer high byte at 0x83, reset zero
// - Stack store increments pointer, then writes
// - Stack top pointer at 0x81 resets 0x07
// - Carry flag from carry or borrow
// - Half carry from low nibble carry/borrow
// - Two user flags, software only
// - Bank select bits choose working bank
// - Signed overflow on sum or difference
// - Overflow when product exceeds 255
// - Overflow on zero divisor
// - Overflow cleared when condition absent
// - Parity bit is read only
// - Primary operand at 0xE0, bit addressable
// - Secondary operand at 0xF0, bit addressable
// - Unassigned addresses are reserved
// - Bit access only at addresses ending 0/8
module ccsr_core
  import ccsr_pkg::*;
(
  input  logic            sys_clk,
  input  logic            arst_n,
  input  ccsr_sfr_req_t   sfr_req,
  input  ccsr_arith_req_t arith_req,
  input  ccsr_stack_req_t stack_req,
  output logic [7:0]      rdata_q,
  output logic            rvalid_q,
  output logic            access_err_q,
  output ccsr_stack_out_t stack_out_q,
  output logic [7:0]      bank_base_q,
  output ccsr_view_t      core_view
);

  // ****************************************************************
  // Register outputs and next values
  // ****************************************************************
  logic [7:0] sp_q;     // Stack top pointer
  logic [7:0] dpl_q;    // Data pointer low
  logic [7:0] dph_q;    // Data pointer high
  logic [7:0] psw_q;    // Flags word
  logic [7:0] acc_q;    // Primary operand
  logic [7:0] b_q;      // Secondary operand
  // Parity and bank base read next values,
  // so neither lags its register
  logic [7:0] psw_d;    // Next flags word
  logic [7:0] acc_d;    // Next primary operand

  // Address hits, one per register
  logic       hit_sp;
  logic       hit_dpl;
  logic       hit_dph;
  logic       hit_psw;
  logic       hit_acc;
  logic       hit_b;

  // ****************************************************************
  // Arithmetic unit
  // ****************************************************************
  logic        arith_go;      // Operation completes now
  logic        arith_wide;    // Operation also writes the secondary operand
  logic [7:0]  arith_b;       // Second operand fed to the unit
  logic [7:0]  arith_lo;      // Result for the primary operand
  logic [7:0]  arith_hi;      // Result for the secondary operand
  ccsr_flags_t arith_flags;   // Flags produced

  assign arith_go   = arith_req.valid;
  // Product and quotient take the secondary register as operand
  assign arith_wide = (arith_req.kind == CCSR_OP_PRODUCT) ||
                      (arith_req.kind == CCSR_OP_QUOTIENT);
  assign arith_b    = arith_wide ? b_q : arith_req.operand;

  // Purely combinational unit: no stall,
  // so operations may run back to back
  ccsr_arith u_arith
  (
    .kind   (arith_req.kind),
    .a      (acc_q),
    .b      (arith_b),
    .cin    (psw_q[CCSR_CY_BIT]),
    .res_lo (arith_lo),
    .res_hi (arith_hi),
    .flags  (arith_flags)
  );

  // ****************************************************************
  // Hardware update terms
  // ****************************************************************
  logic [7:0] acc_hw_mask;   // Primary operand written by arithmetic
  logic [7:0] b_hw_mask;     // Secondary operand written by product/quotient
  logic [7:0] psw_hw_mask;   // Flag bits owned by hardware this cycle
  logic [7:0] psw_hw_val;    // Their new values
  logic [7:0] flag_mask;     // Carry, half carry and range error positions
  logic [7:0] flag_val;      // Arithmetic flag values in place
  logic [7:0] par_mask;      // Parity position
  logic       parity_next;   // Parity of the next primary operand
  logic       do_push;       // Stack store taken
  logic       do_pop;        // Stack remove taken
  logic [7:0] sp_hw_mask;    // Stack top pointer written by hardware
  logic [7:0] sp_hw_val;     // Its new value
  logic [7:0] sp_inc;        // Pointer after increment
  logic [7:0] sp_dec;        // Pointer after decrement

  assign acc_hw_mask = arith_go ? CCSR_MASK_ALL : CCSR_MASK_NONE;
  assign b_hw_mask   = (arith_go && arith_wide) ? CCSR_MASK_ALL : CCSR_MASK_NONE;

  // Hardware and software may meet in one
  // cycle; hardware owns the shared bits
  // Flag positions; user flags and bank select stay out of this mask
  assign flag_mask   = (8'h01 << CCSR_CY_BIT) | (8'h01 << CCSR_AC_BIT) |
                       (8'h01 << CCSR_OV_BIT);
  assign flag_val    = ({7'h00, arith_flags.cy} << CCSR_CY_BIT) |
                       ({7'h00, arith_flags.ac} << CCSR_AC_BIT) |
                       ({7'h00, arith_flags.ov} << CCSR_OV_BIT);
  assign par_mask    = 8'h01 << CCSR_PAR_BIT;

  // Parity follows the operand's next value, so it never lags a cycle
  assign parity_next = ^acc_d;

  assign psw_hw_mask = (arith_go ? flag_mask : CCSR_MASK_NONE) | par_mask;
  assign psw_hw_val  = flag_val | ({7'h00, parity_next} << CCSR_PAR_BIT);

  // Pointer wraps modulo 256 both ways;
  // stack bounds are the program's task
  // Push wins if both strobes arrive together
  assign do_push     = stack_req.push;
  assign do_pop      = stack_req.pop & ~stack_req.push;
  assign sp_inc      = sp_q + 8'h01;
  assign sp_dec      = sp_q - 8'h01;
  assign sp_hw_mask  = (do_push || do_pop) ? CCSR_MASK_ALL : CCSR_MASK_NONE;
  assign sp_hw_val   = do_push ? sp_inc : sp_dec;

  // ****************************************************************
  // Register instances
  // ****************************************************************
  // Byte-only registers drop bit writes,
  // so a refused access cannot corrupt them
  // Stack top pointer
  ccsr_sfr_reg #(
    .ADDR  (CCSR_ADDR_SP),
    .RESET (CCSR_RST_SP),
    .WMASK (CCSR_MASK_ALL)
  ) u_sp
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .req     (sfr_req),
    .hw_mask (sp_hw_mask),
    .hw_val  (sp_hw_val),
    .hit     (hit_sp),
    .d       (),
    .q       (sp_q)
  );

  // Data pointer low byte
  ccsr_sfr_reg #(
    .ADDR  (CCSR_ADDR_DPL),
    .RESET (CCSR_RST_ZERO),
    .WMASK (CCSR_MASK_ALL)
  ) u_dpl
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .req     (sfr_req),
    .hw_mask (CCSR_MASK_NONE),
    .hw_val  (CCSR_RST_ZERO),
    .hit     (hit_dpl),
    .d       (),
    .q       (dpl_q)
  );

  // Data pointer high byte
  ccsr_sfr_reg #(
    .ADDR  (CCSR_ADDR_DPH),
    .RESET (CCSR_RST_ZERO),
    .WMASK (CCSR_MASK_ALL)
  ) u_dph
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .req     (sfr_req),
    .hw_mask (CCSR_MASK_NONE),
    .hw_val  (CCSR_RST_ZERO),
    .hit     (hit_dph),
    .d       (),
    .q       (dph_q)
  );

  // Flags word; the write mask keeps software off the parity bit
  ccsr_sfr_reg #(
    .ADDR  (CCSR_ADDR_PSW),
    .RESET (CCSR_RST_ZERO),
    .WMASK (CCSR_PSW_WMASK)
  ) u_psw
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .req     (sfr_req),
    .hw_mask (psw_hw_mask),
    .hw_val  (psw_hw_val),
    .hit     (hit_psw),
    .d       (psw_d),
    .q       (psw_q)
  );

  // Primary operand
  ccsr_sfr_reg #(
    .ADDR  (CCSR_ADDR_ACC),
    .RESET (CCSR_RST_ZERO),
    .WMASK (CCSR_MASK_ALL)
  ) u_acc
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .req     (sfr_req),
    .hw_mask (acc_hw_mask),
    .hw_val  (arith_lo),
    .hit     (hit_acc),
    .d       (acc_d),
    .q       (acc_q)
  );

  // Secondary operand
  ccsr_sfr_reg #(
    .ADDR  (CCSR_ADDR_B),
    .RESET (CCSR_RST_ZERO),
    .WMASK (CCSR_MASK_ALL)
  ) u_b
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .req     (sfr_req),
    .hw_mask (b_hw_mask),
    .hw_val  (arith_hi),
    .hit     (hit_b),
    .d       (),
    .q       (b_q)
  );

  // ****************************************************************
  // Read path and access checks
  // ****************************************************************
  logic       any_hit;     // Address names a defined register
  logic       bitable;     // Address allows single bit access
  logic       access;      // Any read or write this cycle
  logic       bad_bit;     // Bit access to a byte-only register
  logic [7:0] rd_byte;     // Selected register value
  logic [7:0] rd_bit;      // Selected bit, in bit 0
  logic [7:0] rd_val;      // Value returned

  assign any_hit = hit_sp | hit_dpl | hit_dph | hit_psw | hit_acc | hit_b;
  assign bitable = (sfr_req.addr[CCSR_BIT_LSB_W-1:0] == '0);
  assign access  = sfr_req.rd | sfr_req.wr;
  assign bad_bit = sfr_req.bit_op & ~bitable;

  // Bit reads return the bit in bit 0;
  // byte-only registers answer them with zero
  // Reserved addresses read zero, so no stale value leaks out
  assign rd_byte = hit_sp  ? sp_q  :
                   hit_dpl ? dpl_q :
                   hit_dph ? dph_q :
                   hit_psw ? psw_q :
                   hit_acc ? acc_q :
                   hit_b   ? b_q   :
                   8'h00;
  assign rd_bit  = {7'h00, rd_byte[sfr_req.bit_pos]};
  assign rd_val  = !sfr_req.bit_op ? rd_byte :
                   bitable         ? rd_bit  :
                   8'h00;

  // Read data lands one cycle after the strobe
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q  <= sfr_req.rd ? rd_val : 8'h00;
      rvalid_q <= sfr_req.rd;
    end
  end

  // Flags an access that the hardware ignored; a pulse per access
  // Reserved writes dropped, leaving room
  // for later variants of the register map
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      access_err_q <= 1'b0;
    else
      access_err_q <= access & (~any_hit | bad_bit);
  end

  // ****************************************************************
  // Stack memory strobes
  // ****************************************************************
  // Push addresses the incremented pointer, never the old one
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      stack_out_q <= '0;
    else
    begin
      stack_out_q.wr   <= do_push;
      stack_out_q.rd   <= do_pop;
      stack_out_q.addr <= do_push ? sp_inc : sp_q;
      stack_out_q.data <= do_push ? stack_req.data : 8'h00;
    end
  end

  // ****************************************************************
  // Working bank base
  // ****************************************************************
  // Taken from the next flags word, so it moves with the register
  // Registered, so the output is a flop
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      bank_base_q <= 8'h00;
    else
      bank_base_q <= {3'b000, psw_d[CCSR_BSH_BIT:CCSR_BSL_BIT], 3'b000};
  end

  // ****************************************************************
  // Architectural view
  // ****************************************************************
  // All fields come straight from register flip-flops
  // Wiring only; adds no delay to the flops
  assign core_view.data_pointer_pair = {dph_q, dpl_q};
  assign core_view.sp   = sp_q;
  assign core_view.processor_flags_word  = psw_q;
  assign core_view.acc  = acc_q;
  assign core_view.b    = b_q;

endmodule

/* File: tb/ccsr_sva.sv */
// Concurrent checks on the core special register block ports.
// Assumes one clock domain; bound onto ccsr_core below.
`timescale 1ns/1ps
module ccsr_sva
  import ccsr_pkg::*;
(
  input logic            sys_clk,
  input logic            arst_n,
  input ccsr_sfr_req_t   sfr_req,
  input ccsr_arith_req_t arith_req,
  input ccsr_stack_req_t stack_req,
  input logic [7:0]      rdata_q,
  input logic            rvalid_q,
  input logic            access_err_q,
  input ccsr_stack_out_t stack_out_q,
  input logic [7:0]      bank_base_q,
  input ccsr_view_t      core_view
);
  // ****************************************************************
  // Helper decode
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire        touch  = sfr_req.rd | sfr_req.wr;                     // Any access
  wire        mapped = sfr_req.addr inside {8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0};
  wire        bad_bit = sfr_req.bit_op & (sfr_req.addr[2:0] != 3'h0); // Unaligned bit op
  wire [8:0]  sum9   = core_view.acc + arith_req.operand;            // Sum with carry out
  wire        sum_cy = sum9[8];
  wire [15:0] prod   = core_view.acc * core_view.b;                  // Full product
  wire        prod_ov = |prod[15:8];
  wire [1:0]  uflags = {core_view.processor_flags_word[5], core_view.processor_flags_word[1]};         // Software-only bits
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_reserved_read_zero: assert property (sfr_req.rd && !mapped |=> rvalid_q && rdata_q == 8'h00 && access_err_q)
    else $error("reserved read not refused");
  a_mapped_no_err: assert property (touch && mapped && !bad_bit |=> !access_err_q)
    else $error("error on a defined register");
  a_bit_align_err: assert property (touch && bad_bit |=> access_err_q)
    else $error("unaligned bit access accepted");
  a_parity_tracks: assert property (core_view.processor_flags_word[0] == ^core_view.acc)
    else $error("parity flag wrong");
  a_bank_base_map: assert property (bank_base_q == {3'b000, core_view.processor_flags_word[4:3], 3'b000})
    else $error("bank base wrong");
  a_push_then_store: assert property (stack_req.push |=> stack_out_q.wr && core_view.sp == $past(core_view.sp) + 8'h01
    && stack_out_q.addr == core_view.sp)
    else $error("push order wrong");
  a_sum_carry_out: assert property (arith_req.valid && arith_req.kind == CCSR_OP_SUM |=> core_view.processor_flags_word[7] == $past(sum_cy))
    else $error("sum carry wrong");
  a_product_range: assert property (arith_req.valid && arith_req.kind == CCSR_OP_PRODUCT |=> core_view.processor_flags_word[2] == $past(prod_ov))
    else $error("product range flag wrong");
  a_zero_divisor: assert property (arith_req.valid && arith_req.kind == CCSR_OP_QUOTIENT && core_view.b == 8'h00
    |=> core_view.processor_flags_word[2] && $stable(core_view.acc))
    else $error("zero divisor not flagged");
  a_user_flag_hold: assert property (!(sfr_req.wr && sfr_req.addr == 8'hD0) |=> $stable(uflags))
    else $error("user flag changed by hardware");
endmodule
bind ccsr_core ccsr_sva u_ccsr_sva (.sys_clk(sys_clk), .arst_n(arst_n), .sfr_req(sfr_req), .arith_req(arith_req),
  .stack_req(stack_req), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .access_err_q(access_err_q),
  .stack_out_q(stack_out_q), .bank_base_q(bank_base_q), .core_view(core_view));

/* File: tb/tb.sv */
// Self-checking bench for the core special register block.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module tb import ccsr_pkg::*; ;
  localparam logic [2:0] WR = 3'b010, RD = 3'b100, BW = 3'b011, BR = 3'b101; // {rd,wr,bit_op}
  logic            sys_clk = 1'b0;
  logic            arst_n = 1'b0;
  ccsr_sfr_req_t   sfr_req = '0;
  ccsr_arith_req_t arith_req = '0;
  ccsr_stack_req_t stack_req = '0;
  logic [7:0]      rdata_q;
  logic            rvalid_q;
  logic            access_err_q;
  ccsr_stack_out_t stack_out_q;
  logic [7:0]      bank_base_q;
  ccsr_view_t      core_view;
  int              fail_count = 0;
  int              check_count = 0;
  int              cyc = 0;
  always #5 sys_clk = ~sys_clk;
  ccsr_core u_ccsr_core (.sys_clk(sys_clk), .arst_n(arst_n), .sfr_req(sfr_req), .arith_req(arith_req),
    .stack_req(stack_req), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .access_err_q(access_err_q),
    .stack_out_q(stack_out_q), .bank_base_q(bank_base_q), .core_view(core_view));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One strobe cycle; result settles just after the following edge
  task automatic sfr(input logic [2:0] m, input logic [7:0] a, input logic [2:0] p, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_req <= '{rd: m[2], wr: m[1], bit_op: m[0], addr: a, bit_pos: p, wdata: d};
    @(posedge sys_clk);
    sfr_req <= '0;
    #1;
  endtask
  // Load both operands, run one operation, judge result and flags
  task automatic ar(input ccsr_op_kind_t k, input logic [7:0] a, bv, o, ea, eb, input logic [2:0] ef);
    sfr(WR, 8'hE0, 3'd0, a);
    sfr(WR, 8'hF0, 3'd0, bv);
    @(posedge sys_clk);
    arith_req <= '{valid: 1'b1, kind: k, operand: o};
    @(posedge sys_clk);
    arith_req <= '0;
    #1;
    chk({core_view.acc, core_view.b}, {ea, eb});
    chk({core_view.processor_flags_word[7:6], core_view.processor_flags_word[2]}, ef);
    chk({core_view.processor_flags_word[5], core_view.processor_flags_word[1], core_view.processor_flags_word[0]}, {2'b11, ^ea});
  endtask
  task automatic st(input logic pu, po, input logic [7:0] d);
    @(posedge sys_clk);
    stack_req <= '{push: pu, pop: po, data: d};
    @(posedge sys_clk);
    stack_req <= '0;
    #1;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    logic [7:0] a [6] = '{8'h81, 8'h82, 8'h83, 8'hE0, 8'hF0, 8'h84};
    chk({core_view.sp, core_view.processor_flags_word}, 16'h0700);
    chk(core_view.data_pointer_pair | {core_view.acc, core_view.b}, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      sfr(WR, a[i], 3'd0, 8'h5A ^ 8'(i));
      sfr(RD, a[i], 3'd0, 8'h00);
      chk({rvalid_q, access_err_q, rdata_q}, (i == 5) ? 16'h0300 : {8'h02, 8'h5A ^ 8'(i)});
    end
    chk(core_view.data_pointer_pair, 16'h585B);
    $display("register test done");
  endtask
  task automatic t_flags;
    sfr(WR, 8'hD0, 3'd0, 8'hFF);
    sfr(RD, 8'hD0, 3'd0, 8'h00);
    chk(rdata_q, 8'hFE);
    for (int k = 0; k < 4; k++)
    begin
      sfr(WR, 8'hD0, 3'd0, 8'(k << 3));
      chk(bank_base_q, 8'(k << 3));
    end
    sfr(BW, 8'hD0, 3'd5, 8'h01);
    sfr(BW, 8'hD0, 3'd1, 8'h01);
    chk(core_view.processor_flags_word, 8'h3A);
    sfr(BW, 8'h82, 3'd3, 8'h01);
    chk({access_err_q, core_view.data_pointer_pair[7:0]}, 9'h15B);
    sfr(BW, 8'hE0, 3'd7, 8'h01);
    chk({core_view.acc, core_view.processor_flags_word[0]}, 9'h1B3);
    sfr(BR, 8'hF0, 3'd1, 8'h00);
    chk({access_err_q, rdata_q[0]}, 2'b01);
    sfr(BW, 8'hF0, 3'd1, 8'hFE);
    chk(core_view.b, 8'h5C);
    $display("flags test done");
  endtask
  task automatic t_arith;
    ar(CCSR_OP_SUM, 8'h7F, 8'h00, 8'h01, 8'h80, 8'h00, 3'b011);
    ar(CCSR_OP_SUM, 8'hFF, 8'h00, 8'h01, 8'h00, 8'h00, 3'b110);
    ar(CCSR_OP_SUM_WITH_CARRY, 8'h10, 8'h00, 8'h20, 8'h31, 8'h00, 3'b000);
    ar(CCSR_OP_DIFF_WITH_BORROW, 8'h80, 8'h00, 8'h01, 8'h7F, 8'h00, 3'b011);
    ar(CCSR_OP_PRODUCT, 8'h20, 8'h10, 8'h00, 8'h00, 8'h02, 3'b001);
    ar(CCSR_OP_PRODUCT, 8'h0F, 8'h11, 8'h00, 8'hFF, 8'h00, 3'b000);
    ar(CCSR_OP_QUOTIENT, 8'h55, 8'h00, 8'h00, 8'h55, 8'h00, 3'b001);
    ar(CCSR_OP_QUOTIENT, 8'h64, 8'h07, 8'h00, 8'h0E, 8'h02, 3'b000);
    $display("arithmetic test done");
  endtask
  task automatic t_stack;
    sfr(WR, 8'h81, 3'd0, 8'h07);
    st(1'b1, 1'b0, 8'hAA);
    chk({stack_out_q.wr, stack_out_q.addr, stack_out_q.data}, {1'b1, 8'h08, 8'hAA});
    chk(core_view.sp, 8'h08);
    st(1'b0, 1'b1, 8'h00);
    chk({stack_out_q.rd, stack_out_q.addr, core_view.sp}, {1'b1, 8'h08, 8'h07});
    st(1'b1, 1'b1, 8'h55);
    chk({stack_out_q.wr, stack_out_q.rd, core_view.sp}, {2'b10, 8'h08});
    $display("stack test done");
  endtask
  // Cut a hang short
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    #1;
    t_regs();
    t_flags();
    t_arith();
    t_stack();
    tally_and_finish();
  end
endmodule
